/* File: design/irq_ctrl_pkg.sv */
// constants and carriers for the request, control and error registers
// Behaviour
// - bit 7 selects set or clear of marked flags
// - timer reaching zero raises bit 5
// - transmit, auth, program or checksum done raises bit 4
// - command end or unknown command raises bit 2
// - host loading idle raises no bit 2
// - fifo level status sets bits 1, 0, sticky
// - control bit 5 requests standby, clock running
// - control bit 4 requests power-down, clock stopped
// - bit 3 cipher, set only by auth two
// - bit 2 stops timer, reads zero
// - bit 1 starts timer, reads zero
// - bit 0 purges fifo, reads zero
// - control at 09h, reset 00h, bits 7:6 reserved
// - error flags at 0Ah, reset 40h, read-only
// - key error cleared at key load start, set on format fault
// - enable register set/clear, enabled flags drive irq pin
// - request register at 07h, reset 00h, bit 6 reserved
package irq_ctrl_pkg;
    localparam logic [5:0] ADDR_IRQ_EN   = 6'h06;
    localparam logic [5:0] ADDR_IRQ_REQ  = 6'h07;
    localparam logic [5:0] ADDR_CONTROL  = 6'h09;
    localparam logic [5:0] ADDR_ERROR    = 6'h0a;
    localparam int         SET_CLR_BIT   = 7;
    localparam int         TIMER_BIT     = 5;
    localparam int         TX_BIT        = 4;
    localparam int         RX_BIT        = 3;
    localparam int         IDLE_BIT      = 2;
    localparam int         HIGH_BIT      = 1;
    localparam int         LOW_BIT       = 0;
    localparam int         STANDBY_BIT   = 5;
    localparam int         DEEP_BIT      = 4;
    localparam int         CIPHER_BIT    = 3;
    localparam int         HALT_BIT      = 2;
    localparam int         GO_BIT        = 1;
    localparam int         PURGE_BIT     = 0;
    localparam int         KEY_ERR_BIT   = 6;
    localparam int         OVERRUN_BIT   = 4;
    localparam logic [7:0] FLAG_MASK     = 8'h3f;
    localparam logic [7:0] IRQ_REQ_RESET = 8'h00;
    localparam logic [7:0] IRQ_EN_RESET  = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] ERROR_RESET   = 8'h40;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic timer_zero;
        logic transceive_sent;
        logic auth_sent;
        logic nvm_programmed;
        logic checksum_done;
        logic receiver_done;
        logic command_ended;
        logic unknown_cmd;
        logic host_idle_load;
        logic fifo_high_status;
        logic fifo_low_status;
        logic auth_two_ok;
        logic cipher_off;
        logic key_load_start;
        logic key_format_bad;
        logic queue_overrun;
    } core_evt_s;
endpackage : irq_ctrl_pkg

/* File: design/level_rise.sv */
// rising-edge detector for a status level
`timescale 1ns/1ps
module level_rise (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic level,
    output logic      rise
);
    logic level_q;

    assign rise = level & ~level_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level;
        end
    end
endmodule : level_rise

/* File: design/reader_irq_control_error_regs.sv */
// request, enable, control and error registers of the reader
`timescale 1ns/1ps
module reader_irq_control_error_regs (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    input  wire irq_ctrl_pkg::host_req_s host_req,
    input  wire irq_ctrl_pkg::core_evt_s core_evt,
    output logic [7:0]                   rdata_q,
    output logic                         irq_q,
    output logic                         standby_q,
    output logic                         deep_sleep_req_q,
    output logic                         cipher_active_q,
    output logic                         timer_halt_strobe_q,
    output logic                         timer_go_strobe_q,
    output logic                         queue_purge_strobe_q
);
    import irq_ctrl_pkg::*;

    // ********************************************************
    // address decode
    // ********************************************************
    function automatic logic hit(input host_req_s r, input logic [5:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    logic wr_req;
    logic wr_en;
    logic wr_ctl;
    assign wr_req = hit(host_req, ADDR_IRQ_REQ);
    assign wr_en  = hit(host_req, ADDR_IRQ_EN);
    assign wr_ctl = hit(host_req, ADDR_CONTROL);

    // ********************************************************
    // request and enable flags
    // ********************************************************
    logic       high_rise;
    logic       low_rise;
    logic [5:0] req_set;
    logic [5:0] req_flags;
    logic [5:0] en_flags;

    level_rise u_high (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (core_evt.fifo_high_status),
        .rise    (high_rise)
    );

    level_rise u_low (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .level   (core_evt.fifo_low_status),
        .rise    (low_rise)
    );

    always_comb begin
        req_set = 6'h00;
        req_set[TIMER_BIT] = core_evt.timer_zero;
        req_set[TX_BIT] = core_evt.transceive_sent | core_evt.auth_sent |
                          core_evt.nvm_programmed | core_evt.checksum_done;
        req_set[RX_BIT] = core_evt.receiver_done;
        req_set[IDLE_BIT] = (core_evt.command_ended &
                             ~core_evt.host_idle_load) |
                            core_evt.unknown_cmd;
        req_set[HIGH_BIT] = high_rise;
        req_set[LOW_BIT]  = low_rise;
    end

    set_clear_reg u_req (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_req),
        .wdata   (host_req.wdata),
        .hw_set  (req_set),
        .flags_q (req_flags)
    );

    set_clear_reg u_en (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_en),
        .wdata   (host_req.wdata),
        .hw_set  (6'h00),
        .flags_q (en_flags)
    );

    // ********************************************************
    // control register
    // ********************************************************
    logic       standby_d;
    logic       deep_d;
    logic       cipher_d;
    logic       halt_d;
    logic       go_d;
    logic       purge_d;

    always_comb begin
        standby_d = standby_q;
        deep_d    = deep_sleep_req_q;
        cipher_d  = cipher_active_q;
        halt_d    = 1'b0;
        go_d      = 1'b0;
        purge_d   = 1'b0;
        if (wr_ctl) begin
            standby_d = host_req.wdata[STANDBY_BIT];
            deep_d    = host_req.wdata[DEEP_BIT];
            if (!host_req.wdata[CIPHER_BIT]) begin
                cipher_d = 1'b0;
            end
            halt_d  = host_req.wdata[HALT_BIT];
            go_d    = host_req.wdata[GO_BIT];
            purge_d = host_req.wdata[PURGE_BIT];
        end
        if (core_evt.cipher_off) begin
            cipher_d = 1'b0;
        end
        if (core_evt.auth_two_ok) begin
            cipher_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            standby_q            <= CONTROL_RESET[STANDBY_BIT];
            deep_sleep_req_q     <= CONTROL_RESET[DEEP_BIT];
            cipher_active_q      <= CONTROL_RESET[CIPHER_BIT];
            timer_halt_strobe_q  <= 1'b0;
            timer_go_strobe_q    <= 1'b0;
            queue_purge_strobe_q <= 1'b0;
        end else begin
            standby_q            <= standby_d;
            deep_sleep_req_q     <= deep_d;
            cipher_active_q      <= cipher_d;
            timer_halt_strobe_q  <= halt_d;
            timer_go_strobe_q    <= go_d;
            queue_purge_strobe_q <= purge_d;
        end
    end

    // ********************************************************
    // error flags
    // ********************************************************
    logic key_err_q;
    logic key_err_d;
    logic overrun_q;
    logic overrun_d;

    always_comb begin
        key_err_d = key_err_q;
        overrun_d = overrun_q;
        // clear on start, set on bad format
        if (core_evt.key_load_start) begin
            key_err_d = 1'b0;
        end
        if (core_evt.key_format_bad) begin
            key_err_d = 1'b1;
        end
        if (purge_d) begin
            overrun_d = 1'b0;
        end
        if (core_evt.queue_overrun) begin
            overrun_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_err_q <= ERROR_RESET[KEY_ERR_BIT];
            overrun_q <= ERROR_RESET[OVERRUN_BIT];
        end else begin
            key_err_q <= key_err_d;
            overrun_q <= overrun_d;
        end
    end

    // ********************************************************
    // read data and interrupt pin
    // ********************************************************
    logic [7:0] rdata_d;
    logic       irq_d;

    always_comb begin
        rdata_d = 8'h00;
        if (host_req.rd) begin
            case (host_req.addr)
                ADDR_IRQ_EN:  rdata_d = {2'b00, en_flags};
                // bit 6 and bit 7 read zero
                ADDR_IRQ_REQ: rdata_d = {2'b00, req_flags};
                ADDR_CONTROL: rdata_d = {2'b00, standby_q,
                                         deep_sleep_req_q,
                                         cipher_active_q, 3'b000};
                ADDR_ERROR:   rdata_d = {1'b0, key_err_q, 1'b0,
                                         overrun_q, 4'h0};
                default:      rdata_d = 8'h00;
            endcase
        end
        irq_d = |(req_flags & en_flags);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            irq_q   <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end
endmodule : reader_irq_control_error_regs

/* File: design/set_clear_reg.sv */
// six-flag register with set/clear write and hardware set priority
`timescale 1ns/1ps
module set_clear_reg (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    input  wire logic [5:0] hw_set,
    output logic      [5:0] flags_q
);
    import irq_ctrl_pkg::*;

    logic [5:0] flags_d;

    always_comb begin
        flags_d = flags_q;
        if (wr_en) begin
            if (wdata[SET_CLR_BIT]) begin
                flags_d = flags_q | wdata[5:0];
            end else begin
                flags_d = flags_q & ~wdata[5:0];
            end
        end
        flags_d = flags_d | hw_set;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= 6'h00;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule : set_clear_reg

/* File: tb/core_model.sv */
// event source standing in for the reader core
`timescale 1ns/1ps
module core_model
    import irq_ctrl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] evt_req,
    output irq_ctrl_pkg::core_evt_s core_evt
);
    core_evt_s evt_d;
    // core pulses last one cycle, levels drop after
    always_comb begin
        evt_d = core_evt_s'(evt_req);
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) core_evt <= '0;
        else core_evt <= evt_d;
    end
endmodule : core_model

/* File: tb/regs_chk.sv */
// port relations of the register bank
`timescale 1ns/1ps
module regs_chk
    import irq_ctrl_pkg::*;
(
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    input wire irq_ctrl_pkg::host_req_s host_req,
    input wire irq_ctrl_pkg::core_evt_s core_evt,
    input wire logic [7:0]              rdata_q,
    input wire logic                    standby_q,
    input wire logic                    deep_sleep_req_q,
    input wire logic                    cipher_active_q,
    input wire logic                    timer_halt_strobe_q,
    input wire logic                    timer_go_strobe_q,
    input wire logic                    queue_purge_strobe_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic ctl_wr;
    assign ctl_wr = host_req.wr && host_req.addr == ADDR_CONTROL;
    sequence ctl_w(int b);
        ctl_wr && host_req.wdata[b];
    endsequence
    sequence ctl_rd;
        host_req.rd && host_req.addr == ADDR_CONTROL;
    endsequence
    go_pulse_a:
        assert property (ctl_w(GO_BIT) |=> timer_go_strobe_q)
        else $error("go strobe missing");
    go_cause_a:
        assert property (timer_go_strobe_q |-> $past(ctl_wr))
        else $error("go strobe without write");
    halt_pulse_a:
        assert property (ctl_w(HALT_BIT) |=> timer_halt_strobe_q)
        else $error("halt strobe missing");
    purge_pulse_a:
        assert property (ctl_w(PURGE_BIT) |=> queue_purge_strobe_q)
        else $error("purge strobe missing");
    standby_level_a:
        assert property (ctl_wr |=> standby_q == $past(host_req.wdata[5]))
        else $error("standby level wrong");
    deep_level_a:
        assert property (!ctl_wr |=> $stable(deep_sleep_req_q))
        else $error("deep sleep changed alone");
    cipher_rise_a:
        assert property ($rose(cipher_active_q)
                         |-> $past(core_evt.auth_two_ok))
        else $error("cipher set without auth");
    ctl_read_a:
        assert property (ctl_rd |=> rdata_q[2:0] == 3'h0 &&
                                    rdata_q[7:6] == 2'h0)
        else $error("control strobe bits read back");
    idle_read_a: assert property (!host_req.rd |=> rdata_q == 8'h00)
        else $error("read data outside read");
endmodule : regs_chk
bind reader_irq_control_error_regs regs_chk regs_chk_inst (.ref_clk, .rst_n,
    .host_req, .core_evt, .rdata_q, .standby_q, .deep_sleep_req_q,
    .cipher_active_q, .timer_halt_strobe_q, .timer_go_strobe_q,
    .queue_purge_strobe_q);

/* File: tb/tb_top.sv */
// register tests of the reader register bank
`timescale 1ns/1ps
module tb_top;
    import irq_ctrl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    host_req_s host_req = '0;
    logic [15:0] evt_req = '0;
    core_evt_s core_evt;
    logic [7:0] rdata_q;
    logic irq_q, stb_q, deep_q, ciph_q;
    int n_errors = 0;
    int cmp_count = 0;
    logic [15:0] ev_v [10] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
        16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0040, 16'h0020};
    logic [7:0] ev_f [10] = '{8'h20, 8'h10, 8'h10, 8'h10, 8'h10, 8'h08,
        8'h04, 8'h04, 8'h02, 8'h01};
    core_model core_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .evt_req(evt_req), .core_evt(core_evt));
    reader_irq_control_error_regs reader_irq_control_error_regs_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .host_req(host_req),
        .core_evt(core_evt), .rdata_q(rdata_q), .irq_q(irq_q),
        .standby_q(stb_q), .deep_sleep_req_q(deep_q),
        .cipher_active_q(ciph_q), .timer_halt_strobe_q(),
        .timer_go_strobe_q(), .queue_purge_strobe_q());
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk);
        host_req.wr <= 1'b0;
        host_req.rd <= 1'b0;
        #1;
    endtask : acc
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(rdata_q, e);
    endtask : rd
    task automatic ev(input logic [15:0] v);
        @(posedge ref_clk);
        evt_req <= v;
        @(posedge ref_clk);
        evt_req <= '0;
        repeat (3) @(posedge ref_clk);
    endtask : ev
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(ADDR_IRQ_REQ, 8'h00);
        rd(ADDR_CONTROL, 8'h00);
        rd(ADDR_ERROR, 8'h40);
        rd(6'h3f, 8'h00);
        $display("test reset done");
        acc(1'b1, ADDR_IRQ_REQ, 8'hff);
        rd(ADDR_IRQ_REQ, 8'h3f);
        acc(1'b1, ADDR_IRQ_REQ, 8'h05);
        acc(1'b1, ADDR_IRQ_REQ, 8'h00);
        rd(ADDR_IRQ_REQ, 8'h3a);
        acc(1'b1, ADDR_IRQ_REQ, 8'h3f);
        rd(ADDR_IRQ_REQ, 8'h00);
        $display("test set clear done");
        for (int i = 0; i < 10; i++) begin
            ev(ev_v[i]);
            rd(ADDR_IRQ_REQ, ev_f[i]);
            acc(1'b1, ADDR_IRQ_REQ, 8'h3f);
        end
        ev(16'h0280);
        rd(ADDR_IRQ_REQ, 8'h00);
        acc(1'b1, ADDR_IRQ_REQ, 8'ha0);
        @(posedge ref_clk);
        evt_req <= 16'h8000;
        @(posedge ref_clk);
        evt_req <= '0;
        host_req <= '{wr: 1'b1, rd: 1'b0, addr: ADDR_IRQ_REQ, wdata: 8'h20};
        @(posedge ref_clk);
        host_req.wr <= 1'b0;
        rd(ADDR_IRQ_REQ, 8'h20);
        $display("test events done");
        acc(1'b1, ADDR_IRQ_EN, 8'ha0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({7'h0, irq_q}, 8'h01);
        acc(1'b1, ADDR_IRQ_REQ, 8'h20);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({7'h0, irq_q}, 8'h00);
        $display("test irq done");
        acc(1'b1, ADDR_CONTROL, 8'h0f);
        chk({7'h0, ciph_q}, 8'h00);
        rd(ADDR_CONTROL, 8'h00);
        acc(1'b1, ADDR_CONTROL, 8'hf0);
        chk({6'h0, stb_q, deep_q}, 8'h03);
        ev(16'h0010);
        rd(ADDR_CONTROL, 8'h38);
        ev(16'h0008);
        chk({7'h0, ciph_q}, 8'h00);
        acc(1'b1, ADDR_CONTROL, 8'h00);
        $display("test control done");
        ev(16'h0004);
        rd(ADDR_ERROR, 8'h00);
        ev(16'h0002);
        ev(16'h0001);
        rd(ADDR_ERROR, 8'h50);
        acc(1'b1, ADDR_CONTROL, 8'h01);
        acc(1'b1, ADDR_ERROR, 8'hff);
        rd(ADDR_ERROR, 8'h40);
        $display("test error done");
        wrap_up();
    end
endmodule : tb_top
